// *** ppc_flash_mdl.sv ***
module ppc_flash_mdl #(
  parameter ADDR_W = 17,
  parameter SETUP_NS = 1950,
  parameter BUSY_NS = 3000,
  parameter [7:0] C_PROG = 8'h40,
  parameter [7:0] C_ERASE = 8'h20,
  parameter [7:0] C_STAT = 8'h71,
  parameter [7:0] C_READ = 8'h0F
) (
  input wire rst_i,
  input wire ce_n_i,
  input wire oe_n_i,
  input wire we_n_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [7:0] dq_i,
  output wire [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] stat = 8'h00;
  logic [7:0] last = 8'h00;
  logic ready = 1'b0, busy = 1'b0, done = 1'b0, ok = 1'b0;
  logic [ADDR_W-1:0] base;
  int mode = 0, cnt = 0, n_cmd = 0, n_late = 0;
  wire rd = !ce_n_i && !oe_n_i;
  // poll flags while busy or after an op, else return code or array
  wire [7:0] val = (busy || mode == 3) ? {done, ok, 6'h00} :
    (mode == 2) ? stat : mem[addr_i];
  // released bus shows the inverse of the last value
  assign dq_o = rd ? val : ~last;
  always @* if (rd) last = val;
  initial for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hFF;
  // commands ignored until setup ends, then memory read mode
  always @(negedge rst_i) begin
    ready = 0;
    mode = 0;
    #(SETUP_NS) ready = 1;
  end
  task automatic run(input bit bad, input bit ers);
    busy = 1; done = 0; ok = 0; mode = 3;
    #(BUSY_NS);
    if (ers) for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'hFF;
    stat = bad ? 8'h81 : 8'h00;
    busy = 0; done = 1; ok = !bad;
  endtask
  // write strobe: command or block byte
  always @(posedge we_n_i) if (ready && !ce_n_i && !busy) begin
    if (mode == 1) begin
      if (cnt == 0) base = addr_i;
      mem[addr_i] = mem[addr_i] & dq_i;
      cnt++;
      if (cnt == 128) run(base[6:0] != 0, 0);
    end else begin
      n_cmd++;
      if (dq_i != C_STAT) stat = 8'h00;
      case (dq_i)
        C_PROG: begin mode = 1; cnt = 0; end
        C_ERASE: run(0, 1);
        C_STAT: mode = 2;
        C_READ: mode = 0;
        default: stat[6] = 1;
      endcase
    end
  end
  // a strobe that starts while the array is busy breaks the no-command rule
  always @(negedge we_n_i) if (busy && !ce_n_i) n_late++;
endmodule

// *** ppc_regs.vh ***
`ifndef PPC_REGS_VH
`define PPC_REGS_VH
// How it works
// R1: an auto-program sends one 128-byte block as consecutive byte writes
// R2: unused block locations are sent as the all-ones byte
// R3: each block starts at an address whose low byte is 00 or 80
// R4: a misaligned start still writes but the device flags an address error
// R5: the block address goes out on the second write cycle, never later
// R6: no command write while an auto-program runs
// R7: each block is programmed only once before an erase
// R8: the top data pin reads low while busy and high once finished
// R9: the next pin reads high only on a normal end; low six pins read low
// R10: the polling flags hold until the next command write
// R11: wait at least 1 ms after program or erase before polling
// R12: auto-erase clears the whole array, never a part
// R13: no command write while an auto-erase runs
// R14: status read reports the failure kind and holds it until another command
// R15: status byte bits 7,6,5,4,1,0 are fixed flags; bits 3 and 2 undefined
// R16: wait at least 20 us after the status read command before reading
// R17: the device ignores commands during oscillator and mode setup periods
// R18: allow 10 ms setup plus 10 ms oscillator wait before any command
// R19: after setup the device enters memory read mode by itself
// R20: erase before re-programming already programmed addresses
// R21: after an operation completes the device waits for the next command
// R22: while busy, any read returns the polling flag byte
`define PPC_CLK_HZ 10000000
`define PPC_SETUP_MS 20
`define PPC_POLL_MS 1
`define PPC_STRD_US 20
`define PPC_NXTC_US 20
`define PPC_BLOCK_BYTES 128
`define PPC_BLK_LSB 7
`define PPC_FILL_BYTE 8'hFF
`define PPC_LOW_MASK 8'h7F
// apb register offsets
`define PPC_CTRL_OFF 12'h000
`define PPC_ADDR_OFF 12'h004
`define PPC_DATA_OFF 12'h008
`define PPC_STAT_OFF 12'h00C
`define PPC_CMD_OFF 12'h010
`define PPC_RDATA_OFF 12'h014
// ctrl op codes
`define PPC_OP_PROG 3'h1
`define PPC_OP_ERASE 3'h2
`define PPC_OP_STATUS 3'h3
`define PPC_OP_READ 3'h4
// polling flag positions
`define PPC_POLL_DONE 7
`define PPC_POLL_OK 6
`endif

// *** ppc_top.v ***
`include "ppc_regs.vh"
module ppc_top #(
  parameter SETUP_CYC = 200000,
  parameter POLL_CYC = 10000,
  parameter STRD_CYC = 200,
  parameter NXTC_CYC = 200,
  parameter ADDR_W = 17
) (
  input wire CLK_SYS_I,
  input wire SRST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  output reg CHIP_ENABLE_N_O,
  output reg OUTPUT_ENABLE_N_O,
  output reg WRITE_ENABLE_N_O,
  output reg [ADDR_W-1:0] FLASH_ADDR_O,
  output reg [7:0] FLASH_DQ_O,
  output reg FLASH_DQ_OE_O,
  input wire [7:0] FLASH_DQ_I
);
  localparam S_SETUP = 4'h0;
  localparam S_IDLE = 4'h1;
  localparam S_CMD = 4'h2;
  localparam S_PGAP = 4'h3;
  localparam S_DATA = 4'h4;
  localparam S_WAIT = 4'h5;
  localparam S_POLL = 4'h6;
  localparam S_RD = 4'h7;
  localparam S_CAP = 4'h8;
  localparam S_GAP = 4'h9;
  localparam PH_W = 2'h3;
  reg [3:0] st_q;
  reg [17:0] cnt_q;
  reg [1:0] ph_q;
  reg [7:0] idx_q;
  reg [2:0] op_q;
  reg [2:0] ctrl_op_q;
  reg busy_q;
  reg done_q;
  reg ok_q;
  reg align_err_q;
  reg [7:0] cmd_prog_q;
  reg [7:0] cmd_erase_q;
  reg [7:0] cmd_stat_q;
  reg [7:0] cmd_read_q;
  reg [ADDR_W-1:0] base_q;
  reg [7:0] rdata_q;
  reg [7:0] mem_q [0:`PPC_BLOCK_BYTES-1];
  reg [7:0] s1_q, s2_q, s3_q;
  reg [7:0] din_q;
  reg [6:0] fill_q;
  wire apb_wr;
  wire apb_rd;
  reg [7:0] cmd_byte;
  localparam [7:0] BLK_END = `PPC_BLOCK_BYTES;
  localparam [7:0] BLK_LAST = `PPC_BLOCK_BYTES - 1;
  localparam BLK_N = 1 << (ADDR_W - `PPC_BLK_LSB);
  reg [`PPC_BLOCK_BYTES-1:0] vld_q;
  reg [BLK_N-1:0] blk_q;
  wire blk_used;
  // programmed-since-erase mark of the block the address register points at
  assign blk_used = blk_q[base_q[ADDR_W-1:`PPC_BLK_LSB]];
  // input pins pass three flops; a change counts once stages 2 and 3 agree
  always @(posedge CLK_SYS_I) begin
    s1_q <= FLASH_DQ_I;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (s2_q == s3_q) begin
      din_q <= s3_q;
    end
  end
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && !PREADY_O;
  assign apb_rd = PSEL_I && PENABLE_I && !PWRITE_I && !PREADY_O;
  // command code chosen per operation
  always @* begin
    case (op_q)
      `PPC_OP_PROG: cmd_byte = cmd_prog_q;
      `PPC_OP_ERASE: cmd_byte = cmd_erase_q;
      `PPC_OP_STATUS: cmd_byte = cmd_stat_q;
      default: cmd_byte = cmd_read_q;
    endcase
  end
  // apb slave: one wait state, unmapped reads zero with pslverr
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      ctrl_op_q <= 3'h0;
      base_q <= {ADDR_W{1'b0}};
      fill_q <= 7'h00;
      cmd_prog_q <= 8'h00;
      cmd_erase_q <= 8'h00;
      cmd_stat_q <= 8'h00;
      cmd_read_q <= 8'h00;
    end else begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      PSLVERR_O <= 1'b0;
      if (st_q != S_IDLE || busy_q) begin
        ctrl_op_q <= 3'h0;
      end
      if (apb_wr) begin
        case (PADDR_I)
          `PPC_CTRL_OFF: begin
            // a block already written since the last erase is refused
            if (st_q == S_IDLE && !busy_q &&
                !(PWDATA_I[2:0] == `PPC_OP_PROG && blk_used)) begin
              ctrl_op_q <= PWDATA_I[2:0]; // R6 R7 R13 R20
            end
          end
          `PPC_ADDR_OFF: base_q <= PWDATA_I[ADDR_W-1:0];
          `PPC_DATA_OFF: begin
            fill_q <= fill_q + 7'h01;
          end
          `PPC_CMD_OFF: begin
            cmd_prog_q <= PWDATA_I[7:0];
            cmd_erase_q <= PWDATA_I[15:8];
            cmd_stat_q <= PWDATA_I[23:16];
            cmd_read_q <= PWDATA_I[31:24];
          end
          default: PSLVERR_O <= 1'b1;
        endcase
      end
      if (apb_rd) begin
        case (PADDR_I)
          `PPC_STAT_OFF: PRDATA_O <= {24'h000000, align_err_q, 3'h0,
            busy_q, st_q == S_IDLE, ok_q, done_q};
          `PPC_RDATA_OFF: PRDATA_O <= {24'h000000, rdata_q};
          `PPC_ADDR_OFF: PRDATA_O <= {{(32-ADDR_W){1'b0}}, base_q};
          default: begin
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b1;
          end
        endcase
      end
      if (st_q == S_CMD && op_q == `PPC_OP_PROG) begin
        fill_q <= 7'h00;
      end
    end
  end
  // block buffer, filled through the data register
  always @(posedge CLK_SYS_I) begin
    if (apb_wr && PADDR_I == `PPC_DATA_OFF) begin
      mem_q[fill_q] <= PWDATA_I[7:0];
    end
  end
  // written marks; a byte never written this block goes out as all-ones
  always @(posedge CLK_SYS_I) begin
    if (SRST_I || (st_q == S_GAP && op_q == `PPC_OP_PROG)) begin
      vld_q <= {`PPC_BLOCK_BYTES{1'b0}}; // R2
    end else if (apb_wr && PADDR_I == `PPC_DATA_OFF) begin
      vld_q[fill_q] <= 1'b1;
    end
  end
  // pin sequencer
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_q <= S_SETUP;
      cnt_q <= 18'h00000;
      ph_q <= 2'h0;
      idx_q <= 8'h00;
      op_q <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ok_q <= 1'b0;
      align_err_q <= 1'b0;
      rdata_q <= 8'h00;
      CHIP_ENABLE_N_O <= 1'b1;
      OUTPUT_ENABLE_N_O <= 1'b1;
      WRITE_ENABLE_N_O <= 1'b1;
      FLASH_ADDR_O <= {ADDR_W{1'b0}};
      FLASH_DQ_O <= 8'h00;
      FLASH_DQ_OE_O <= 1'b0;
      blk_q <= {BLK_N{1'b0}}; // array taken as blank; erase first if unsure
    end else begin
      case (st_q)
        S_SETUP: begin
          // hold off every command for setup plus oscillator time
          if (cnt_q == SETUP_CYC[17:0] - 18'h00001) begin // R17 R18
            cnt_q <= 18'h00000;
            st_q <= S_IDLE; // R19
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        S_IDLE: begin
          CHIP_ENABLE_N_O <= 1'b1;
          OUTPUT_ENABLE_N_O <= 1'b1;
          if (ctrl_op_q != 3'h0) begin
            op_q <= ctrl_op_q;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            idx_q <= 8'h00;
            ph_q <= 2'h0;
            // flag a misaligned start; the device will too
            align_err_q <= (ctrl_op_q == `PPC_OP_PROG) &&
              ((base_q[7:0] & `PPC_LOW_MASK) != 8'h00); // R3 R4
            st_q <= S_CMD;
            // erase frees every block; a program claims its own
            if (ctrl_op_q == `PPC_OP_ERASE) begin
              blk_q <= {BLK_N{1'b0}}; // R20
            end else if (ctrl_op_q == `PPC_OP_PROG) begin
              blk_q[base_q[ADDR_W-1:`PPC_BLK_LSB]] <= 1'b1; // R7
            end
          end
        end
        S_CMD, S_DATA: begin
          // one write strobe: setup, low, high with data held
          CHIP_ENABLE_N_O <= 1'b0;
          FLASH_DQ_OE_O <= 1'b1;
          if (st_q == S_CMD) begin
            FLASH_DQ_O <= cmd_byte;
          end else begin
            FLASH_DQ_O <= vld_q[idx_q[6:0]] ? mem_q[idx_q[6:0]] :
              `PPC_FILL_BYTE; // R1 R2
            FLASH_ADDR_O <= base_q + {{(ADDR_W-7){1'b0}}, idx_q[6:0]}; // R5
          end
          ph_q <= ph_q + 2'h1;
          WRITE_ENABLE_N_O <= !(ph_q == 2'h1 || ph_q == 2'h2);
          if (ph_q == PH_W) begin
            cnt_q <= 18'h00000;
            st_q <= S_PGAP;
          end
        end
        S_PGAP: begin
          // command cycle spacing, then data phase or wait
          FLASH_DQ_OE_O <= 1'b0; // data held one cycle past the strobe
          if (st_q == S_PGAP && op_q == `PPC_OP_PROG && idx_q != 8'h00 &&
              idx_q != `PPC_BLOCK_BYTES) begin
            st_q <= S_DATA;
          end else if (cnt_q == NXTC_CYC[17:0] - 18'h00001) begin
            cnt_q <= 18'h00000;
            if (op_q == `PPC_OP_PROG && idx_q == 8'h00) begin
              st_q <= S_DATA;
            end else begin
              st_q <= S_WAIT;
            end
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
          if (st_q == S_PGAP && ph_q == 2'h0 && cnt_q == 18'h00000 &&
              op_q == `PPC_OP_PROG && idx_q != 8'h00 &&
              idx_q != `PPC_BLOCK_BYTES) begin
            cnt_q <= 18'h00000;
          end
        end
        S_WAIT: begin
          // 1 ms before polling, 20 us before a status or data read
          if (cnt_q == ((op_q == `PPC_OP_PROG || op_q == `PPC_OP_ERASE) ?
              POLL_CYC[17:0] : STRD_CYC[17:0]) - 18'h00001) begin // R11 R16
            cnt_q <= 18'h00000;
            st_q <= S_RD;
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        S_RD: begin
          CHIP_ENABLE_N_O <= 1'b0;
          OUTPUT_ENABLE_N_O <= 1'b0;
          FLASH_ADDR_O <= base_q;
          cnt_q <= cnt_q + 18'h00001;
          if (cnt_q == 18'h00004) begin
            cnt_q <= 18'h00000;
            st_q <= S_CAP;
          end
        end
        S_CAP: begin
          OUTPUT_ENABLE_N_O <= 1'b1;
          rdata_q <= din_q;
          if ((op_q == `PPC_OP_PROG || op_q == `PPC_OP_ERASE) &&
              !din_q[`PPC_POLL_DONE]) begin // R8 R22
            st_q <= S_POLL;
          end else begin
            done_q <= 1'b1;
            ok_q <= din_q[`PPC_POLL_OK] && din_q[5:0] == 6'h00; // R9 R10
            st_q <= S_GAP;
          end
        end
        S_POLL: begin
          // still busy: re-read after a short pause
          if (cnt_q == STRD_CYC[17:0] - 18'h00001) begin
            cnt_q <= 18'h00000;
            st_q <= S_RD;
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        S_GAP: begin
          CHIP_ENABLE_N_O <= 1'b1;
          busy_q <= 1'b0; // R21
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
      // advance the block byte counter after each data strobe
      if (st_q == S_DATA && ph_q == PH_W) begin
        idx_q <= idx_q + 8'h01;
      end else if (st_q == S_CMD && ph_q == PH_W &&
          op_q == `PPC_OP_PROG) begin
        idx_q <= 8'h00;
      end
      if (st_q == S_DATA && ph_q == PH_W &&
          idx_q == BLK_LAST) begin
        idx_q <= BLK_END;
      end
    end
  end
endmodule

// *** ppc_top_asserts.sv ***
module ppc_top_asserts #(parameter SETUP_CYC = 20) (
  input wire CLK_SYS_I,
  input wire SRST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire CHIP_ENABLE_N_O,
  input wire OUTPUT_ENABLE_N_O,
  input wire WRITE_ENABLE_N_O,
  input wire FLASH_DQ_OE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  integer cnt_q;
  // cycles since reset release, saturating at the setup span
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) cnt_q <= 0;
    else if (cnt_q < SETUP_CYC) cnt_q <= cnt_q + 1;
  end
  sequence s_access; $rose(PSEL_I && PENABLE_I); endsequence
  sequence s_we_pulse;
    !WRITE_ENABLE_N_O [*2] ##[1:6] WRITE_ENABLE_N_O;
  endsequence
  chk_ready_one_wait: assert property (s_access |=> PREADY_O)
    else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  chk_we_ce: assert property (!WRITE_ENABLE_N_O |-> !CHIP_ENABLE_N_O)
    else $error("write strobe without chip enable");
  chk_we_oe_excl: assert property (
    WRITE_ENABLE_N_O || OUTPUT_ENABLE_N_O)
    else $error("write and read strobe together");
  chk_dq_hold: assert property ($rose(WRITE_ENABLE_N_O) |->
    FLASH_DQ_OE_O) else $error("data released with the strobe");
  chk_we_drive: assert property (!WRITE_ENABLE_N_O |-> FLASH_DQ_OE_O)
    else $error("data not driven during write");
  chk_rd_float: assert property (!OUTPUT_ENABLE_N_O |-> !FLASH_DQ_OE_O)
    else $error("data driven during read");
  chk_we_width: assert property ($fell(WRITE_ENABLE_N_O) |-> s_we_pulse)
    else $error("write strobe width wrong");
  chk_setup_quiet: assert property (cnt_q < SETUP_CYC |->
    WRITE_ENABLE_N_O && OUTPUT_ENABLE_N_O) else $error("strobe in setup");
endmodule

bind ppc_top ppc_top_asserts #(.SETUP_CYC(SETUP_CYC)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .CHIP_ENABLE_N_O(CHIP_ENABLE_N_O), .OUTPUT_ENABLE_N_O(OUTPUT_ENABLE_N_O),
  .WRITE_ENABLE_N_O(WRITE_ENABLE_N_O), .FLASH_DQ_OE_O(FLASH_DQ_OE_O));

// *** tb_prom_mode_program_erase_status.sv ***
module tb_prom_mode_program_erase_status;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdv;
  logic [32:0] q_ex [$], q_m [$], me, mm;
  logic [7:0] exp_b [0:127];
  wire [31:0] prdata;
  wire pready, pslverr, ce_n, oe_n, we_n, dq_oe;
  wire [16:0] faddr;
  wire [7:0] dq_o, mdl_q, dq_i;
  int err_count = 0, n_checks = 0, seed = 18676;
  assign dq_i = dq_oe ? dq_o : mdl_q;
  initial forever #50 clk = ~clk;
  ppc_top #(.SETUP_CYC(20), .POLL_CYC(10), .STRD_CYC(5), .NXTC_CYC(5)) dut (
    .CLK_SYS_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CHIP_ENABLE_N_O(ce_n), .OUTPUT_ENABLE_N_O(oe_n),
    .WRITE_ENABLE_N_O(we_n), .FLASH_ADDR_O(faddr), .FLASH_DQ_O(dq_o),
    .FLASH_DQ_OE_O(dq_oe), .FLASH_DQ_I(dq_i));
  ppc_flash_mdl mdl (.rst_i(rst), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .addr_i(faddr), .dq_i(dq_i), .dq_o(mdl_q));
  task chk(input [32:0] got, input [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; reads leave their expectation in the queue
  task apb(input bit wr, input [11:0] a, input [31:0] d,
    input [32:0] ex, input [32:0] m);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    if (!wr) begin q_ex.push_back(ex); q_m.push_back(m); end
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task wr(input [11:0] a, input [31:0] d); apb(1, a, d, 0, 0); endtask
  task rd(input [11:0] a, input [32:0] ex, input [32:0] m);
    apb(0, a, 32'h0, ex, m);
  endtask
  task wait_idle; do rd(12'h00C, 0, 0); while (rdv[2] !== 1'b1); endtask
  // read monitor compares against the oldest note
  always @(posedge clk) if (psel && penable && !pwrite && pready === 1'b1) begin
    me = q_ex.pop_front();
    mm = q_m.pop_front();
    if (mm != 0) chk({pslverr, prdata} & mm, me & mm);
  end
  initial begin #3000000; err_count++; close_out; end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rd(12'h020, 33'h100000000, 33'h100000000); // unmapped
    wr(12'h010, {8'h0F, 8'h71, 8'h20, 8'h40});
    wr(12'h000, 32'h2);
    repeat (30) @(posedge clk);
    chk(mdl.n_cmd, 0);
    $display("test setup done");
    wr(12'h000, 32'h2);
    wait_idle;
    rd(12'h00C, 33'h3, 33'h3);
    $display("test erase done");
    for (int k = 0; k < 2; k++) begin
      wr(12'h004, k ? 32'h105 : 32'h080);
      for (int i = 0; i < 128; i++)
        exp_b[i] = i < 100 ? 8'($random(seed)) : 8'hFF;
      for (int i = 0; i < 100; i++) wr(12'h008, {24'h0, exp_b[i]});
      wr(12'h000, 32'h1);
      wr(12'h000, 32'h2);
      wait_idle;
      rd(12'h00C, k ? 33'h81 : 33'h3, 33'h83);
      if (!k) begin
        for (int i = 0; i < 128; i++)
          chk(mdl.mem[128 + i], exp_b[i]);
      end
      wr(12'h000, 32'h3);
      wait_idle;
      rd(12'h014, k ? 33'h81 : 33'h0, 33'hF3);
      if (!k) begin
        wr(12'h004, 32'h087);
        wr(12'h000, 32'h4);
        wait_idle;
        rd(12'h014, {25'h0, exp_b[7]}, 33'hFF);
      end
      $display("test program %0d done", k);
    end
    wr(12'h004, 32'h080);
    wr(12'h000, 32'h1);
    rd(12'h00C, 33'h4, 33'hC);
    $display("test reprogram done");
    chk(mdl.n_cmd, 6);
    chk(mdl.n_late, 0);
    close_out;
  end
endmodule
